// *** hdl/fpes_sequencer.v ***
// Flash program, sector erase, chip erase and sector erase suspend sequencer with an APB port.
`timescale 1ns/1ps
`include "fpes_regs.vh"
module fpes_sequencer #(
    parameter AW = 6,
    parameter SECT_BITS = 2,
    parameter PROG_CYC = 32,
    parameter STEP_CYC = 16
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire chip_enable_n,
    input wire address_valid_n,
    input wire write_enable_n,
    input wire output_enable_n,
    input wire [AW-1:0] flash_addr,
    input wire [15:0] data_in,
    output reg [15:0] data_out,
    output wire data_oe,
    output reg ready_busy_n
);
    localparam NSECT = 1 << SECT_BITS;
    localparam DEPTH = 1 << AW;
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_PROG = 7'h02;
    localparam [6:0] S_ETMO = 7'h04;
    localparam [6:0] S_ERASE = 7'h08;
    localparam [6:0] S_SUSP = 7'h10;
    localparam [6:0] S_SPROG = 7'h20;
    localparam [6:0] S_CERASE = 7'h40;
    // Reload values are worked out as integers and cut to the counter widths.
    localparam integer ETMO_I = `FPES_ETMO_CYC - 1;
    localparam integer POLL_I = `FPES_POLL_CYC - 1;
    localparam integer STEP_I = STEP_CYC - 1;
    localparam integer PROG_I = PROG_CYC - 1;
    localparam [10:0] ETMO_LD = ETMO_I[10:0];
    localparam [8:0] POLL_LD = POLL_I[8:0];
    localparam [8:0] STEP_LD = STEP_I[8:0];
    localparam [8:0] PROG_LD = PROG_I[8:0];
    localparam [AW-1:0] LAST_ADDR = {AW{1'b1}};

    // Sector and bank taken from the upper address bits.
    function [SECT_BITS-1:0] sect_of;
        input [AW-1:0] a;
        begin
            sect_of = a[AW-1:AW-SECT_BITS];
        end
    endfunction

    function bank_of;
        input [AW-1:0] a;
        begin
            bank_of = a[AW-1];
        end
    endfunction

    // Flash array; contents are not reset, as in a real memory.
    reg [15:0] mem [0:DEPTH-1];

    reg [31:0] ctrl_q;
    reg [6:0] state_q;
    reg [2:0] seq_q;
    reg [NSECT-1:0] sel_q;
    reg [10:0] tmr_q;
    reg [8:0] poll_q;
    reg [8:0] stp_q;
    reg [AW-1:0] lat_addr_q;
    reg [AW-1:0] p_addr_q;
    reg [15:0] p_data_q;
    reg [AW-1:0] e_ptr_q;
    reg phase_q;
    reg op_bank_q;
    reg susp_pend_q;
    reg tl_q;
    reg we_q;
    reg rd_q;
    reg tog_q;
    reg etog_q;

    wire [NSECT-1:0] prot = ctrl_q[`FPES_CTRL_PROT_LSB +: NSECT];
    wire strict = ctrl_q[`FPES_CTRL_STRICT];
    wire [7:0] cmd = data_in[7:0];
    // A bus write completes on the rising edge of the write strobe with the chip selected.
    wire wr_commit = ~chip_enable_n & write_enable_n & ~we_q;
    wire we_low = ~chip_enable_n & ~write_enable_n;
    wire rd_act = ~chip_enable_n & ~output_enable_n & write_enable_n;
    wire rd_start = rd_act & ~rd_q;
    wire step_done = (stp_q == 9'h000);
    wire ptr_last = (e_ptr_q == LAST_ADDR);
    wire e_hit = sel_q[sect_of(e_ptr_q)];
    wire [15:0] p_old = mem[p_addr_q];
    wire prog_bad = |(~p_old & p_data_q);
    wire erasing = (state_q == S_ERASE) | (state_q == S_CERASE);
    wire programming = (state_q == S_PROG) | (state_q == S_SPROG);
    wire [AW-1:0] rd_addr = flash_addr;
    wire rd_bank = bank_of(rd_addr);
    wire rd_sel = sel_q[sect_of(rd_addr)];

    // Single array write port shared by the program and erase engines.
    reg mem_we;
    reg [AW-1:0] mem_wa;
    reg [15:0] mem_wd;
    always @* begin
        mem_we = 1'b0;
        mem_wa = p_addr_q;
        mem_wd = p_old & p_data_q;
        if (programming && step_done) begin
            mem_we = 1'b1;
        end else if (erasing && step_done && e_hit) begin
            mem_we = 1'b1;
            mem_wa = e_ptr_q;
            mem_wd = phase_q ? `FPES_ERASED : `FPES_ZEROS;
        end
    end

    always @(posedge pclk) begin
        if (clk_en && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Main sequencer: command decode, embedded algorithms and timers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            seq_q <= 3'd0;
            sel_q <= {NSECT{1'b0}};
            tmr_q <= 11'h000;
            poll_q <= 9'h000;
            stp_q <= 9'h000;
            lat_addr_q <= {AW{1'b0}};
            p_addr_q <= {AW{1'b0}};
            p_data_q <= 16'h0000;
            e_ptr_q <= {AW{1'b0}};
            phase_q <= 1'b0;
            op_bank_q <= 1'b0;
            susp_pend_q <= 1'b0;
            tl_q <= 1'b0;
            we_q <= 1'b1;
        end else if (clk_en) begin
            we_q <= write_enable_n | chip_enable_n;
            if (~chip_enable_n && ~address_valid_n && output_enable_n) begin
                lat_addr_q <= flash_addr;
            end
            if (poll_q != 9'h000) begin
                poll_q <= poll_q - 9'h001;
            end
            if (!step_done) begin
                stp_q <= stp_q - 9'h001;
            end
            case (state_q)
                S_IDLE, S_SUSP: begin
                    if (wr_commit) begin
                        if (cmd == `FPES_CMD_RESET && seq_q != 3'd3) begin
                            seq_q <= 3'd0;
                            if (state_q == S_IDLE) begin
                                tl_q <= 1'b0;
                            end
                        end else if (state_q == S_SUSP && seq_q == 3'd0
                                     && cmd == `FPES_CMD_RESUME) begin
                            state_q <= S_ERASE;
                            stp_q <= STEP_LD;
                        end else begin
                            case (seq_q)
                                3'd0: seq_q <= (cmd == `FPES_CMD_UNLK1) ? 3'd1 : 3'd0;
                                3'd1: seq_q <= (cmd == `FPES_CMD_UNLK2) ? 3'd2 : 3'd0;
                                3'd2: begin
                                    if (cmd == `FPES_CMD_PROG) begin
                                        seq_q <= 3'd3;
                                    end else if (cmd == `FPES_CMD_ERSETUP
                                                 && state_q == S_IDLE) begin
                                        seq_q <= 3'd4;
                                    end else begin
                                        seq_q <= 3'd0;
                                    end
                                end
                                3'd3: begin
                                    seq_q <= 3'd0;
                                    // Program data cycle starts the program algorithm.
                                    if (state_q == S_IDLE) begin
                                        state_q <= S_PROG;
                                        p_addr_q <= lat_addr_q;
                                        p_data_q <= data_in;
                                        stp_q <= PROG_LD;
                                    end else if (!sel_q[sect_of(lat_addr_q)]) begin
                                        state_q <= S_SPROG;
                                        p_addr_q <= lat_addr_q;
                                        p_data_q <= data_in;
                                        stp_q <= PROG_LD;
                                    end
                                end
                                3'd4: seq_q <= (cmd == `FPES_CMD_UNLK1) ? 3'd5 : 3'd0;
                                3'd5: seq_q <= (cmd == `FPES_CMD_UNLK2) ? 3'd6 : 3'd0;
                                3'd6: begin
                                    seq_q <= 3'd0;
                                    if (cmd == `FPES_CMD_SECT) begin
                                        state_q <= S_ETMO;
                                        sel_q <= ~prot & ({{(NSECT-1){1'b0}}, 1'b1}
                                                 << sect_of(lat_addr_q));
                                        op_bank_q <= bank_of(lat_addr_q);
                                        tmr_q <= ETMO_LD;
                                    end else if (cmd == `FPES_CMD_CHIP) begin
                                        state_q <= S_CERASE;
                                        sel_q <= ~prot;
                                        e_ptr_q <= {AW{1'b0}};
                                        phase_q <= 1'b0;
                                        stp_q <= STEP_LD;
                                    end
                                end
                                default: seq_q <= 3'd0;
                            endcase
                        end
                    end
                end
                S_PROG, S_SPROG: begin
                    // Writes are ignored until the program step completes.
                    if (step_done) begin
                        state_q <= (state_q == S_SPROG) ? S_SUSP : S_IDLE;
                        if (strict && prog_bad) begin
                            tl_q <= 1'b1;
                        end
                    end
                end
                S_ETMO: begin
                    if (we_low) begin
                        tmr_q <= ETMO_LD;
                    end else if (tmr_q != 11'h000) begin
                        tmr_q <= tmr_q - 11'h001;
                    end
                    if (wr_commit) begin
                        if (cmd == `FPES_CMD_SECT) begin
                            sel_q <= sel_q | (~prot & ({{(NSECT-1){1'b0}}, 1'b1}
                                     << sect_of(lat_addr_q)));
                        end else if (cmd == `FPES_CMD_SUSP) begin
                            state_q <= S_SUSP;
                            poll_q <= POLL_LD;
                            e_ptr_q <= {AW{1'b0}};
                            phase_q <= 1'b0;
                        end else begin
                            state_q <= S_IDLE;
                            sel_q <= {NSECT{1'b0}};
                        end
                    end else if (tmr_q == 11'h000 && !we_low) begin
                        state_q <= S_ERASE;
                        e_ptr_q <= {AW{1'b0}};
                        phase_q <= 1'b0;
                        stp_q <= STEP_LD;
                    end
                end
                S_ERASE, S_CERASE: begin
                    if (wr_commit && state_q == S_ERASE && cmd == `FPES_CMD_SUSP) begin
                        susp_pend_q <= 1'b1;
                    end
                    // One array word per step; the pass of zeros precedes the pass of ones.
                    if (step_done) begin
                        stp_q <= STEP_LD;
                        e_ptr_q <= e_ptr_q + {{(AW-1){1'b0}}, 1'b1};
                        if (ptr_last) begin
                            phase_q <= 1'b1;
                        end
                        if (ptr_last && phase_q) begin
                            state_q <= S_IDLE;
                            sel_q <= {NSECT{1'b0}};
                            susp_pend_q <= 1'b0;
                        end else if (susp_pend_q
                                     || (wr_commit && state_q == S_ERASE
                                         && cmd == `FPES_CMD_SUSP)) begin
                            state_q <= S_SUSP;
                            susp_pend_q <= 1'b0;
                            poll_q <= POLL_LD;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Status and toggle reporting on the data bus.
    reg use_stat;
    reg stat_bank;
    reg [15:0] stat_word;
    always @* begin
        stat_bank = programming ? bank_of(p_addr_q) : op_bank_q;
        use_stat = 1'b0;
        stat_word = 16'h0000;
        case (state_q)
            S_PROG, S_SPROG: begin
                use_stat = (rd_bank == stat_bank);
                stat_word[`FPES_DQ_POLL] = ~p_data_q[7];
                stat_word[`FPES_DQ_TOG] = tog_q;
            end
            S_ETMO, S_ERASE: begin
                use_stat = (rd_bank == op_bank_q);
                stat_word[`FPES_DQ_TOG] = tog_q;
                stat_word[`FPES_DQ_ETMR] = (state_q == S_ERASE);
                stat_word[`FPES_DQ_ETOG] = etog_q;
            end
            S_CERASE: begin
                use_stat = 1'b1;
                stat_word[`FPES_DQ_TOG] = tog_q;
                stat_word[`FPES_DQ_ETMR] = 1'b1;
                stat_word[`FPES_DQ_ETOG] = etog_q;
            end
            S_SUSP: begin
                use_stat = ((rd_bank == op_bank_q) && (poll_q != 9'h000)) || rd_sel;
                stat_word[`FPES_DQ_POLL] = 1'b1;
                stat_word[`FPES_DQ_TOG] = tog_q;
                stat_word[`FPES_DQ_ETOG] = etog_q;
            end
            default: begin
                use_stat = tl_q && (rd_bank == bank_of(p_addr_q));
                stat_word[`FPES_DQ_POLL] = ~p_data_q[7];
                stat_word[`FPES_DQ_TOG] = tog_q;
            end
        endcase
        stat_word[`FPES_DQ_TL] = tl_q;
    end

    assign data_oe = rd_act;

    // Read data register; at the start of a status read tog_q flips outside suspend, and etog_q flips for a selected sector or in chip erase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out <= 16'h0000;
            rd_q <= 1'b0;
            tog_q <= 1'b0;
            etog_q <= 1'b0;
            ready_busy_n <= 1'b1;
        end else if (clk_en) begin
            rd_q <= rd_act;
            ready_busy_n <= ~(programming | erasing | (state_q == S_ETMO));
            if (rd_act) begin
                data_out <= use_stat ? stat_word : mem[rd_addr];
            end
            if (rd_start && use_stat) begin
                if (state_q != S_SUSP) begin
                    tog_q <= ~tog_q;
                end
                if (rd_sel || state_q == S_CERASE) begin
                    etog_q <= ~etog_q;
                end
            end
        end
    end

    // APB slave: zero wait states, error on unmapped addresses.
    wire apb_hit = (paddr == `FPES_CTRL_OFF) || (paddr == `FPES_STAT_OFF);
    assign pready = clk_en;
    assign pslverr = psel & penable & ~apb_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `FPES_CTRL_RST;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            if (psel && penable && pwrite && paddr == `FPES_CTRL_OFF) begin
                ctrl_q <= pwdata;
            end
            if (psel && !penable && !pwrite) begin
                prdata <= 32'h00000000;
                if (paddr == `FPES_CTRL_OFF) begin
                    prdata <= ctrl_q;
                end else if (paddr == `FPES_STAT_OFF) begin
                    prdata[6:0] <= state_q;
                    prdata[`FPES_STAT_SEL_LSB +: NSECT] <= sel_q;
                    prdata[`FPES_STAT_TL] <= tl_q;
                    prdata[`FPES_STAT_SPEND] <= susp_pend_q;
                    prdata[`FPES_STAT_RDY] <= ready_busy_n;
                end
            end
        end
    end
endmodule

// *** hdl/fpes_regs.vh ***
// Constants shared by the flash program and erase sequencer.
`ifndef FPES_REGS_VH
`define FPES_REGS_VH

// Register map on the peripheral bus.
`define FPES_CTRL_OFF 12'h000
`define FPES_STAT_OFF 12'h004
`define FPES_CTRL_RST 32'h00000000
`define FPES_CTRL_STRICT 0
`define FPES_CTRL_PROT_LSB 8
`define FPES_STAT_SEL_LSB 8
`define FPES_STAT_TL 16
`define FPES_STAT_SPEND 17
`define FPES_STAT_RDY 18

// Command bytes on the flash data bus.
`define FPES_CMD_UNLK1 8'hAA
`define FPES_CMD_UNLK2 8'h55
`define FPES_CMD_PROG 8'hA0
`define FPES_CMD_ERSETUP 8'h80
`define FPES_CMD_SECT 8'h30
`define FPES_CMD_CHIP 8'h10
`define FPES_CMD_SUSP 8'hB0
`define FPES_CMD_RESUME 8'h30
`define FPES_CMD_RESET 8'hF0

// Status bit positions and data patterns.
`define FPES_DQ_POLL 7
`define FPES_DQ_TOG 6
`define FPES_DQ_TL 5
`define FPES_DQ_ETMR 3
`define FPES_DQ_ETOG 2
`define FPES_ERASED 16'hFFFF
`define FPES_ZEROS 16'h0000

// Timing in microseconds and the derived clock counts.
`define FPES_CLK_MHZ 20
`define FPES_ETMO_US 80
`define FPES_ETMO_CYC (`FPES_ETMO_US * `FPES_CLK_MHZ)
`define FPES_POLL_US 8
`define FPES_POLL_CYC (`FPES_POLL_US * `FPES_CLK_MHZ)
`define FPES_SUSP_MAX_US 20
`define FPES_SUSP_MAX_CYC (`FPES_SUSP_MAX_US * `FPES_CLK_MHZ)

`endif

// *** bench/fpes_host_model.sv ***
// Behavioural host controller that drives the parallel flash bus.
`timescale 1ns/1ps
module fpes_host_model (
    input wire pclk,
    output logic chip_enable_n,
    output logic address_valid_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic [5:0] flash_addr,
    output logic [15:0] data_in,
    output logic rd_stb
);
    // The active-low strobes idle high and rd_stb idles low from time zero.
    initial begin
        chip_enable_n = 1'b1;
        address_valid_n = 1'b1;
        write_enable_n = 1'b1;
        output_enable_n = 1'b1;
        flash_addr = 6'h00;
        data_in = 16'h0000;
        rd_stb = 1'b0;
    end
    // Address cycle, then data cycle, then release with the lines inverted.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        chip_enable_n <= 1'b0;
        address_valid_n <= 1'b0;
        flash_addr <= a;
        @(posedge pclk);
        address_valid_n <= 1'b1;
        write_enable_n <= 1'b0;
        data_in <= d;
        @(posedge pclk);
        write_enable_n <= 1'b1;
        @(posedge pclk);
        chip_enable_n <= 1'b1;
        flash_addr <= ~a;
        data_in <= ~d;
        @(posedge pclk);
    endtask
    // Read cycle; the strobe marks the cycle whose data is settled.
    task automatic rd(input logic [5:0] a);
        chip_enable_n <= 1'b0;
        output_enable_n <= 1'b0;
        flash_addr <= a;
        repeat (2) @(posedge pclk);
        rd_stb <= 1'b1;
        @(posedge pclk);
        rd_stb <= 1'b0;
        chip_enable_n <= 1'b1;
        output_enable_n <= 1'b1;
        flash_addr <= ~a;
        @(posedge pclk);
    endtask
endmodule

// *** bench/fpes_monitor.sv ***
// Port-level assertions for the flash sequencer.
`timescale 1ns/1ps
module fpes_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire chip_enable_n,
    input wire write_enable_n,
    input wire output_enable_n,
    input wire [15:0] data_out,
    input wire data_oe,
    input wire ready_busy_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded bus and strobe conditions.
    wire rd = !chip_enable_n && !output_enable_n && write_enable_n;
    wire bad = paddr != 12'h000 && paddr != 12'h004;
    wire setup_rd = psel && !penable && !pwrite;
    property p_err1; psel && penable |-> pslverr == bad; endproperty
    a_err1: assert property (p_err1) else $error("pslverr wrong in access");
    property p_err0; !(psel && penable) |-> !pslverr; endproperty
    a_err0: assert property (p_err0) else $error("pslverr outside access");
    property p_rdz; setup_rd && bad |=> prdata == 32'h00000000; endproperty
    a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
    property p_hot; setup_rd && paddr == 12'h004 |=> $onehot(prdata[6:0]); endproperty
    a_hot: assert property (p_hot) else $error("state field not one-hot");
    property p_oe; data_oe == rd; endproperty
    a_oe: assert property (p_oe) else $error("data_oe wrong");
    property p_rst; $rose(presetn) |-> ready_busy_n; endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_busy;
        $fell(ready_busy_n) |->
            $past(!write_enable_n && !chip_enable_n, 3) || $past(!write_enable_n, 4);
    endproperty
    a_busy: assert property (p_busy) else $error("busy without write");
    property p_len; $fell(ready_busy_n) |-> !ready_busy_n [*8]; endproperty
    a_len: assert property (p_len) else $error("busy too short");
    property p_hold; !rd |=> $stable(data_out); endproperty
    a_hold: assert property (p_hold) else $error("data_out moved idle");
    c_bad: cover property (psel && penable && bad);
    c_rd: cover property (rd && !ready_busy_n);
    c_busy: cover property ($rose(ready_busy_n));
endmodule
bind fpes_sequencer fpes_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .chip_enable_n(chip_enable_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n));

// *** bench/tb.sv ***
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/1ps
`include "fpes_regs.vh"
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module tb;
    typedef struct {string nm; logic [32:0] e; logic [32:0] m;} fpes_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, ce_n, avd_n, we_n, oe_n, data_oe, ready_busy_n, rd_stb;
    wire [5:0] fa;
    wire [15:0] fd, data_out;
    fpes_note_t q[$];
    logic [32:0] got;
    logic [15:0] d0, d1;
    int failures = 0;
    int n_compared = 0;
    int seed;
    always #25 pclk = ~pclk;
    fpes_sequencer uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_enable_n(ce_n), .address_valid_n(avd_n),
        .write_enable_n(we_n), .output_enable_n(oe_n), .flash_addr(fa), .data_in(fd),
        .data_out(data_out), .data_oe(data_oe), .ready_busy_n(ready_busy_n));
    fpes_host_model host (.pclk(pclk), .chip_enable_n(ce_n), .address_valid_n(avd_n),
        .write_enable_n(we_n), .output_enable_n(oe_n), .flash_addr(fa), .data_in(fd),
        .rd_stb(rd_stb));
    // Compares the oldest note whenever a read result appears.
    always @(posedge pclk) begin
        if ((psel && penable && pready && !pwrite) || rd_stb) begin
            got = rd_stb ? {17'h0, data_out} : {pslverr, prdata};
            if (q.size() == 0) begin
                failures++;
                $display("CHECK FAILED unexpected result got %h", got);
            end else begin
                `CHK(q[0].nm, q[0].e & q[0].m, got & q[0].m)
                void'(q.pop_front());
            end
        end
    end
    task automatic conclude();
        if (q.size() != 0) failures++;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) failures++;
        if (pready !== 1'b1) conclude();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ar(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        q.push_back('{"apb", e, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic fr(input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
        q.push_back('{"flash", {17'h0, e}, {17'h0, m}});
        host.rd(a);
    endtask
    task automatic cmd(input logic [5:0] a, input logic [7:0] c);
        host.wr(a, {8'h00, c});
    endtask
    task automatic unlock();
        cmd(6'h00, `FPES_CMD_UNLK1);
        cmd(6'h00, `FPES_CMD_UNLK2);
    endtask
    task automatic prog(input logic [5:0] a, input logic [15:0] d);
        unlock();
        cmd(6'h00, `FPES_CMD_PROG);
        host.wr(a, d);
    endtask
    task automatic esetup();
        unlock();
        cmd(6'h00, `FPES_CMD_ERSETUP);
        unlock();
    endtask
    // Busy falls two edges after a commit, so the first edges are skipped.
    task automatic wait_rdy(input int lim);
        int k;
        k = 0;
        repeat (3) @(posedge pclk);
        while (ready_busy_n !== 1'b1 && k < lim) begin
            @(posedge pclk);
            k++;
        end
        if (ready_busy_n !== 1'b1) failures++;
        if (ready_busy_n !== 1'b1) conclude();
    endtask
    // Main sequence: registers, chip erase, program, reset, sector erase.
    initial begin
        seed = $urandom(32'h5AD3);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ar(`FPES_CTRL_OFF, 33'h0, {33{1'b1}});
        apb(1'b1, `FPES_STAT_OFF, 32'hFFFFFFFF);
        ar(`FPES_STAT_OFF, 33'h40001, 33'h4007F);
        apb(1'b1, 12'h008, 32'h5);
        ar(12'h008, 33'h100000000, {33{1'b1}});
        esetup();
        cmd(6'h00, `FPES_CMD_CHIP);
        cmd(6'h10, `FPES_CMD_SUSP);
        fr(6'h10, 16'h0000, 16'h0080);
        ar(`FPES_STAT_OFF, 33'h40, 33'h7F);
        wait_rdy(5000);
        for (int i = 0; i < 64; i += 9) fr(i[5:0], 16'hFFFF, 16'hFFFF);
        d0 = 16'($urandom()) & 16'hFFFE;
        prog(6'h05, d0);
        fr(6'h05, ~d0, 16'h0080);
        cmd(6'h00, `FPES_CMD_RESET);
        ar(`FPES_STAT_OFF, 33'h2, 33'h7F);
        wait_rdy(200);
        fr(6'h05, d0, 16'hFFFF);
        prog(6'h05, 16'hFFFF);
        wait_rdy(200);
        fr(6'h05, d0, 16'hFFFF);
        apb(1'b1, `FPES_CTRL_OFF, 32'h1);
        prog(6'h05, 16'hFFFF);
        wait_rdy(200);
        ar(`FPES_STAT_OFF, 33'h50001, 33'h5007F);
        fr(6'h05, 16'h0020, 16'h0020);
        cmd(6'h00, `FPES_CMD_RESET);
        ar(`FPES_STAT_OFF, 33'h40001, 33'h5007F);
        fr(6'h05, d0, 16'hFFFF);
        prog(6'h07, 16'h1234);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ar(`FPES_STAT_OFF, 33'h40001, 33'h4007F);
        d1 = 16'($urandom());
        prog(6'h30, d1);
        wait_rdy(200);
        apb(1'b1, `FPES_CTRL_OFF, 32'h800);
        esetup();
        cmd(6'h00, `FPES_CMD_CHIP);
        wait_rdy(5000);
        fr(6'h30, d1, 16'hFFFF);
        fr(6'h05, 16'hFFFF, 16'hFFFF);
        apb(1'b1, `FPES_CTRL_OFF, 32'h0);
        prog(6'h05, d0);
        wait_rdy(200);
        esetup();
        cmd(6'h00, `FPES_CMD_SECT);
        fr(6'h01, 16'h0000, 16'h0008);
        repeat (10) @(posedge pclk);
        cmd(6'h00, `FPES_CMD_RESET);
        wait_rdy(100);
        fr(6'h05, d0, 16'hFFFF);
        esetup();
        cmd(6'h10, `FPES_CMD_SECT);
        cmd(6'h20, `FPES_CMD_SECT);
        repeat (1610) @(posedge pclk);
        fr(6'h10, 16'h0008, 16'h0088);
        cmd(6'h10, `FPES_CMD_SUSP);
        repeat (20) @(posedge pclk);
        fr(6'h10, 16'h0080, 16'h0080);
        fr(6'h30, d1, 16'hFFFF);
        cmd(6'h00, `FPES_CMD_RESET);
        fr(6'h05, 16'h0080, 16'h0080);
        prog(6'h03, d1);
        wait_rdy(200);
        ar(`FPES_STAT_OFF, 33'h10, 33'h7F);
        repeat (120) @(posedge pclk);
        fr(6'h03, d1, 16'hFFFF);
        cmd(6'h10, `FPES_CMD_RESUME);
        cmd(6'h10, `FPES_CMD_RESUME);
        wait_rdy(6000);
        fr(6'h10, 16'hFFFF, 16'hFFFF);
        fr(6'h20, 16'hFFFF, 16'hFFFF);
        fr(6'h05, d0, 16'hFFFF);
        conclude();
    end
endmodule
